// >>> hw/pio_pkg.sv
// Package of constants and types for the peripheral port and tape path.
package pio_pkg;
  // ----------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------
  localparam int WORD_W       = 18;
  localparam int CHAR_W       = 8;
  localparam int DEVA_W       = 4;
  localparam int CLASS_LSB    = 7;
  localparam int CLASS_W      = 4;
  localparam int OPK_LSB      = 0;
  localparam int OPK_W        = 2;
  localparam int OPS_LSB      = 0;
  localparam int OPS_W        = 7;
  localparam int NCHAN        = 4;
  localparam int NIRQ         = 3;
  localparam int TAPE_SHIFT   = 7;
  localparam logic [15:0] FULLOP_CLASSES = 16'hF000;
  // ----------------------------------------------------------------
  // Tape device addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_READER = 4'h1;
  localparam logic [3:0] DEV_PUNCH  = 4'h2;
  localparam logic [3:0] DEV_TTY    = 4'h3;
  // ----------------------------------------------------------------
  // APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_ACC    = 8'h00;
  localparam logic [7:0] A_AUX    = 8'h04;
  localparam logic [7:0] A_INSTR  = 8'h08;
  localparam logic [7:0] A_CMD    = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_BADDR  = 8'h14;
  localparam logic [7:0] A_BCNT   = 8'h18;
  localparam logic [7:0] A_CTRLW  = 8'h1C;
  localparam logic [7:0] A_TSTAT  = 8'h20;
  localparam logic [7:0] A_ATU    = 8'h24;
  // Command codes written to A_CMD.
  localparam logic [3:0] C_WORD_IN  = 4'h1;
  localparam logic [3:0] C_WORD_OUT = 4'h2;
  localparam logic [3:0] C_BLK_IN   = 4'h3;
  localparam logic [3:0] C_BLK_OUT  = 4'h4;
  localparam logic [3:0] C_CTRL     = 4'h5;
  localparam logic [3:0] C_TAPE_IN  = 4'h6;
  localparam logic [3:0] C_TAPE_OUT = 4'h7;
  localparam logic [3:0] C_ONLINE   = 4'h8;
  localparam logic [3:0] C_OFFLINE  = 4'h9;
  localparam logic [WORD_W-1:0] ACC_RST = 18'h00000;

  typedef enum logic [1:0] {PIO_OPK_DATA_IN, PIO_OPK_DATA_OUT, PIO_OPK_CTRL, PIO_OPK_STAT} pio_opk_t;

  function automatic logic [CLASS_W-1:0] pio_class(input logic [WORD_W-1:0] ins);
    pio_class = ins[CLASS_LSB +: CLASS_W];
  endfunction
endpackage

// >>> hw/pio_tape.sv
// Tape character path: reader merge, punch buffer, device busy and on-line mode.
`timescale 1ns/1ps
module pio_tape
  import pio_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Request
  input  wire logic              req,
  input  wire logic              is_in,
  input  wire logic              set_online,
  input  wire logic              set_offline,
  input  wire logic [DEVA_W-1:0] dev,
  input  wire logic [WORD_W-1:0] acc,
  // Devices
  input  wire logic [CHAR_W-1:0] rd_char,
  input  wire logic              rd_ready,
  input  wire logic              pun_ready,
  input  wire logic              tty_ready,
  output logic       [CHAR_W-1:0] pun_char,
  output logic                   pun_strobe,
  output logic                   rd_ack,
  // Result
  output logic                   done,
  output logic                   stall,
  output logic                   acc_we,
  output logic       [WORD_W-1:0] acc_new,
  output logic                   online
);
  logic dev_ok;
  logic known;
  always_comb begin
    known = (dev == DEV_READER) || (dev == DEV_PUNCH) || (dev == DEV_TTY);
    case (dev)
      DEV_READER: dev_ok = rd_ready;
      DEV_PUNCH:  dev_ok = pun_ready;
      DEV_TTY:    dev_ok = tty_ready;
      default:    dev_ok = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      online <= 1'b0;
    end else if (set_online) begin
      online <= 1'b1;
    end else if (set_offline) begin
      online <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      done       <= 1'b0;
      stall      <= 1'b0;
      acc_we     <= 1'b0;
      acc_new    <= ACC_RST;
      pun_char   <= 8'h00;
      pun_strobe <= 1'b0;
      rd_ack     <= 1'b0;
    end else begin
      done       <= 1'b0;
      acc_we     <= 1'b0;
      pun_strobe <= 1'b0;
      rd_ack     <= 1'b0;
      stall      <= 1'b0;
      if (req) begin
        if (!dev_ok && known && !online) begin
          stall <= 1'b1;
        end else if (!dev_ok && known) begin
          done <= 1'b1;
        end else begin
          done <= 1'b1;
          if (is_in) begin
            // Shift seven and merge; bit 8 keeps the old bit 1 folded in. A teleprinter code keeps its parity on track 8.
            acc_new    <= {acc[WORD_W-1-TAPE_SHIFT:0], 7'h00} | {10'h000, rd_char};
            acc_we     <= 1'b1;
            rd_ack     <= 1'b1;
          end else begin
            pun_char   <= acc[CHAR_W-1:0];
            pun_strobe <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// >>> hw/pio_arb.sv
// Fixed-priority arbiter for the autonomous store channels.
`timescale 1ns/1ps
module pio_arb
  import pio_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Requests and grants
  input  wire logic [NCHAN-1:0] req,
  input  wire logic             cpu_busy,
  output logic       [NCHAN-1:0] gnt
);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gnt <= 4'h0;
    end else begin
      gnt <= 4'h0;
      // The processor keeps the bus when it needs it; channels steal only free cycles.
      if (!cpu_busy) begin
        if (req[0]) gnt <= 4'h1;
        else if (req[1]) gnt <= 4'h2;
        else if (req[2]) gnt <= 4'h4;
        else if (req[3]) gnt <= 4'h8;
      end
    end
  end
endmodule

// >>> hw/pio_top.sv
// Processor-side peripheral port with tape path and autonomous store channels.
// ------------------------------------------------------------------
// Overview of operation
// - Single-word command moves one 18-bit word between accumulator and peripheral.
// - Block command moves words between peripheral and consecutive store using accumulator and auxiliary.
// - Autonomous channels move words to store while the processor continues.
// - Tape path carries 8-bit characters selected by a 4-bit device address.
// - Standard interface data is a full 18-bit parallel word.
// - Class number 0 to 15 comes from instruction bits 8 to 11.
// - Instruction bits 1 and 2 give the operation kind.
// - Some classes receive instruction bits 1 to 7 as operation specifier.
// - Control words may follow an operation to refine it.
// - Three interrupt lines are served by priority.
// - Four autonomous channels, each serving up to eight peripherals.
// - Channels steal single store cycles; processor logic arbitrates the bus.
// - Tape input shifts accumulator left seven and loads eight low bits.
// - New bit 8 is old bit 1 OR tape bit 8.
// - Tape output copies eight low accumulator bits to punch when ready.
// - Teleprinter codes are seven bits with parity on track 8.
// - Off-line mode stalls until the addressed tape device is ready.
// - On-line mode treats a busy tape device instruction as no-op.
// - On-line only by command; off-line by command or reset.
// - Status word shows one busy bit per tape device.
// ------------------------------------------------------------------
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module pio_top
  import pio_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic       [31:0]      prdata,
  output logic                   pslverr,
  // Standard peripheral interface
  output logic       [WORD_W-1:0] spi_dout,
  input  wire logic [WORD_W-1:0] spi_din,
  output logic       [CLASS_W-1:0] spi_class,
  output logic       [OPS_W-1:0] spi_op,
  output logic                   spi_ctrl_word,
  output logic                   spi_out_stb,
  output logic                   spi_in_stb,
  input  wire logic              spi_ack,
  input  wire logic [NIRQ-1:0]   spi_irq,
  output logic       [1:0]       irq_level,
  output logic                   irq_active,
  // Store port for block transfers
  output logic                   st_we,
  output logic       [15:0]      st_addr,
  output logic       [WORD_W-1:0] st_wdata,
  input  wire logic [WORD_W-1:0] st_rdata,
  // Autonomous channels
  input  wire logic [NCHAN-1:0]  atu_req,
  output logic       [NCHAN-1:0] atu_gnt,
  // Tape devices
  input  wire logic [CHAR_W-1:0] rd_char,
  input  wire logic              rd_ready,
  output logic                   rd_ack,
  input  wire logic              pun_ready,
  input  wire logic              tty_ready,
  output logic       [CHAR_W-1:0] pun_char,
  output logic                   pun_strobe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PIO_IDLE, PIO_WORD, PIO_BLK_RD, PIO_BLK_XF, PIO_TAPE} pio_state_t;
  pio_state_t state_reg;
  logic [WORD_W-1:0] acc_reg;
  logic [WORD_W-1:0] aux_reg;
  logic [WORD_W-1:0] instr_reg;
  logic [15:0]       baddr_reg;
  logic [15:0]       bcnt_reg;
  logic              blk_in_reg;
  logic              word_in_reg;
  logic              tape_req;
  logic              tape_in_reg;
  logic [DEVA_W-1:0] tape_dev_reg;
  logic              t_done, t_stall, t_we, t_online;
  logic [WORD_W-1:0] t_acc;
  logic [NCHAN-1:0]  gnt_w;
  logic              busy;
  logic              wr_en, rd_en, cmd_wr;
  logic [3:0]        cmd;

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign cmd_wr = wr_en && (paddr == A_CMD) && (state_reg == PIO_IDLE);
  assign cmd    = pwdata[3:0];
  assign busy   = (state_reg != PIO_IDLE);
  assign tape_req = (state_reg == PIO_TAPE) && !t_done;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  pio_tape u_tape (
    .clk        (clk),
    .resetn     (resetn),
    .req        (tape_req),
    .is_in      (tape_in_reg),
    .set_online (cmd_wr && (cmd == C_ONLINE)),
    .set_offline(cmd_wr && (cmd == C_OFFLINE)),
    .dev        (tape_dev_reg),
    .acc        (acc_reg),
    .rd_char    (rd_char),
    .rd_ready   (rd_ready),
    .pun_ready  (pun_ready),
    .tty_ready  (tty_ready),
    .pun_char   (pun_char),
    .pun_strobe (pun_strobe),
    .rd_ack     (rd_ack),
    .done       (t_done),
    .stall      (t_stall),
    .acc_we     (t_we),
    .acc_new    (t_acc),
    .online     (t_online)
  );

  // Block transfers hold the store port, so channels see it busy meanwhile.
  pio_arb u_arb (
    .clk     (clk),
    .resetn  (resetn),
    .req     (atu_req),
    .cpu_busy(state_reg == PIO_BLK_RD || state_reg == PIO_BLK_XF),
    .gnt     (gnt_w)
  );
  assign atu_gnt = gnt_w;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      spi_class <= 4'h0;
      spi_op    <= 7'h00;
    end else begin
      spi_class <= pio_class(instr_reg);
      if (FULLOP_CLASSES[pio_class(instr_reg)]) begin
        spi_op <= instr_reg[OPS_LSB +: OPS_W];
      end else begin
        spi_op <= {5'h00, instr_reg[OPK_LSB +: OPK_W]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg     <= PIO_IDLE;
      acc_reg       <= ACC_RST;
      aux_reg       <= ACC_RST;
      instr_reg     <= ACC_RST;
      baddr_reg     <= 16'h0000;
      bcnt_reg      <= 16'h0000;
      blk_in_reg    <= 1'b0;
      word_in_reg   <= 1'b0;
      tape_in_reg   <= 1'b0;
      tape_dev_reg  <= 4'h0;
      spi_dout      <= ACC_RST;
      spi_out_stb   <= 1'b0;
      spi_in_stb    <= 1'b0;
      spi_ctrl_word <= 1'b0;
      st_we         <= 1'b0;
      st_addr       <= 16'h0000;
      st_wdata      <= ACC_RST;
    end else begin
      st_we <= 1'b0;
      if (wr_en && !busy) begin
        case (paddr)
          A_ACC:   acc_reg   <= pwdata[WORD_W-1:0];
          A_AUX:   aux_reg   <= pwdata[WORD_W-1:0];
          A_INSTR: instr_reg <= pwdata[WORD_W-1:0];
          A_BADDR: baddr_reg <= pwdata[15:0];
          A_BCNT:  bcnt_reg  <= pwdata[15:0];
          default: ;
        endcase
      end
      case (state_reg)
        PIO_IDLE: begin
          if (cmd_wr) begin
            case (cmd)
              C_WORD_IN, C_WORD_OUT, C_CTRL: begin
                state_reg     <= PIO_WORD;
                word_in_reg   <= (cmd == C_WORD_IN);
                spi_ctrl_word <= (cmd == C_CTRL);
                spi_dout      <= acc_reg;
                spi_out_stb   <= (cmd != C_WORD_IN);
                spi_in_stb    <= (cmd == C_WORD_IN);
              end
              C_BLK_IN, C_BLK_OUT: begin
                if (bcnt_reg != 16'h0000) begin
                  blk_in_reg <= (cmd == C_BLK_IN);
                  aux_reg    <= {2'b00, bcnt_reg};
                  state_reg  <= (cmd == C_BLK_IN) ? PIO_BLK_XF : PIO_BLK_RD;
                  spi_in_stb <= (cmd == C_BLK_IN);
                  st_addr    <= baddr_reg;
                end
              end
              C_TAPE_IN, C_TAPE_OUT: begin
                state_reg    <= PIO_TAPE;
                tape_in_reg  <= (cmd == C_TAPE_IN);
                tape_dev_reg <= pwdata[7:4];
              end
              default: ;
            endcase
          end
        end
        PIO_WORD: begin
          if (spi_ack) begin
            if (word_in_reg) acc_reg <= spi_din;
            spi_out_stb   <= 1'b0;
            spi_in_stb    <= 1'b0;
            spi_ctrl_word <= 1'b0;
            state_reg     <= PIO_IDLE;
          end
        end
        PIO_BLK_RD: begin
          // Output block: fetch a word into the accumulator, then hand it out.
          acc_reg     <= st_rdata;
          spi_dout    <= st_rdata;
          spi_out_stb <= 1'b1;
          state_reg   <= PIO_BLK_XF;
        end
        PIO_BLK_XF: begin
          if (spi_ack) begin
            spi_out_stb <= 1'b0;
            if (blk_in_reg) begin
              acc_reg  <= spi_din;
              st_wdata <= spi_din;
              st_we    <= 1'b1;
            end
            aux_reg <= aux_reg - 18'h00001;
            if (aux_reg == 18'h00001) begin
              spi_in_stb <= 1'b0;
              state_reg  <= PIO_IDLE;
            end else begin
              state_reg <= blk_in_reg ? PIO_BLK_XF : PIO_BLK_RD;
            end
          end
          // Input steps after its store write lands; output steps once the word is taken.
          if (st_we || (spi_ack && !blk_in_reg)) st_addr <= st_addr + 16'h0001;
        end
        PIO_TAPE: begin
          if (t_we) acc_reg <= t_acc;
          if (t_done) state_reg <= PIO_IDLE;
        end
        default: state_reg <= PIO_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt priority
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_level  <= 2'h0;
      irq_active <= 1'b0;
    end else begin
      irq_active <= |spi_irq;
      if (spi_irq[0]) irq_level <= 2'h1;
      else if (spi_irq[1]) irq_level <= 2'h2;
      else if (spi_irq[2]) irq_level <= 2'h3;
      else irq_level <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          A_ACC:    prdata <= {14'h0000, acc_reg};
          A_AUX:    prdata <= {14'h0000, aux_reg};
          A_INSTR:  prdata <= {14'h0000, instr_reg};
          A_STATUS: prdata <= {28'h0000000, t_stall, t_online, busy, 1'b0};
          A_BADDR:  prdata <= {16'h0000, baddr_reg};
          A_BCNT:   prdata <= {16'h0000, bcnt_reg};
          A_TSTAT:  prdata <= {29'h00000000, !tty_ready, !pun_ready, !rd_ready};
          A_ATU:    prdata <= {24'h000000, atu_gnt, atu_req};
          default:  prdata <= 32'h00000000;
        endcase
        pslverr <= !(paddr == A_ACC || paddr == A_AUX || paddr == A_INSTR || paddr == A_STATUS ||
                     paddr == A_BADDR || paddr == A_BCNT || paddr == A_TSTAT || paddr == A_ATU);
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence tape_in_req_s;
    state_reg == PIO_TAPE && tape_in_reg && tape_req &&
      ((tape_dev_reg == DEV_READER && rd_ready) || (tape_dev_reg == DEV_TTY && tty_ready));
  endsequence
  tape_merge_a: assert property (@(posedge clk) disable iff (!resetn)
    tape_in_req_s |=> t_we && t_acc[7] == ($past(acc_reg[0]) | $past(rd_char[7])))
    else $error("tape bit 8 merge wrong");
  tape_shift_a: assert property (@(posedge clk) disable iff (!resetn)
    tape_in_req_s |=> t_acc[17:8] == $past(acc_reg[10:1]))
    else $error("tape shift wrong");
  punch_copy_a: assert property (@(posedge clk) disable iff (!resetn)
    pun_strobe |-> pun_char == acc_reg[7:0])
    else $error("punch char not accumulator low byte");
  offline_stall_a: assert property (@(posedge clk) disable iff (!resetn)
    (tape_req && !t_online && ((tape_dev_reg == DEV_READER && !rd_ready) ||
                               (tape_dev_reg == DEV_PUNCH && !pun_ready))) |=> t_stall && !t_done)
    else $error("off-line did not stall");
  online_noop_a: assert property (@(posedge clk) disable iff (!resetn)
    (tape_req && t_online && tape_dev_reg == DEV_PUNCH && !pun_ready) |=> t_done && !pun_strobe)
    else $error("busy on-line op not no-op");
  online_cmd_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(t_online) |-> $past(cmd_wr && cmd == C_ONLINE))
    else $error("on-line entered without command");
  class_dec_a: assert property (@(posedge clk) disable iff (!resetn)
    ##1 spi_class == $past(instr_reg[10:7]))
    else $error("class field wrong");
  arb_prio_a: assert property (@(posedge clk) disable iff (!resetn)
    (atu_req[0] && state_reg == PIO_IDLE) |=> atu_gnt == 4'h1)
    else $error("channel 0 not granted first");
  word_done_a: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == PIO_WORD && spi_ack && word_in_reg) |=> acc_reg == $past(spi_din) && state_reg == PIO_IDLE)
    else $error("single word input lost");
endmodule

// >>> dv/pio_periph.sv
// Behavioural peripheral and store on the far side of the standard interface.
`timescale 1ns/1ps
module pio_periph
  import pio_pkg::*;
(
  // Clock and pacing
  input  wire logic              clk,
  input  wire logic [3:0]        slow,
  // Standard interface
  input  wire logic              spi_out_stb,
  input  wire logic              spi_in_stb,
  input  wire logic              spi_ctrl_word,
  input  wire logic [WORD_W-1:0] spi_dout,
  output logic      [WORD_W-1:0] spi_din,
  output logic                   spi_ack,
  // Store
  input  wire logic              st_we,
  input  wire logic [15:0]       st_addr,
  input  wire logic [WORD_W-1:0] st_wdata,
  output logic      [WORD_W-1:0] st_rdata
);
  // ------
  // Model
  // ------
  localparam logic [WORD_W-1:0] STEP = 18'h01111;
  logic [WORD_W-1:0] word = 18'h2A5C3;
  logic [WORD_W-1:0] last_out = 18'h00000;
  logic              last_cw = 1'h0;
  logic [3:0]        cnt = 4'h0;
  logic [WORD_W-1:0] mem [16];
  initial begin
    spi_ack = 1'h0;
    for (int k = 0; k < 16; k++) mem[k] = 18'h00000;
  end
  // Outside an input request the bus shows the inverse, so stale data cannot pass.
  assign spi_din  = spi_in_stb ? word : ~word;
  assign st_rdata = mem[st_addr[3:0]];
  always @(posedge clk) begin
    if ((spi_out_stb || spi_in_stb) && !spi_ack) begin
      cnt <= (cnt >= slow) ? 4'h0 : cnt + 4'h1;
      spi_ack <= (cnt >= slow);
    end else begin
      spi_ack <= 1'h0;
    end
    if (spi_ack && spi_out_stb) begin
      last_out <= spi_dout;
      last_cw <= spi_ctrl_word;
    end
    if (spi_ack && spi_in_stb) word <= word + STEP;
    if (st_we) mem[st_addr[3:0]] <= st_wdata;
  end
endmodule

// >>> dv/tb_peripheral_io_port_tape_path.sv
// Self-checking bench for the peripheral port and tape path.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_peripheral_io_port_tape_path
  import pio_pkg::*;
;
  // ------
  // Signals
  // ------
  logic        clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic        rd_ready = 1'h0, pun_ready = 1'h0, tty_ready = 1'h0, pready, pslverr, rd_ack, pun_strobe;
  logic        st_we, spi_ctrl_word, spi_out_stb, spi_in_stb, spi_ack, irq_active;
  logic [7:0]  paddr = 8'h00, rd_char = 8'h00, pun_char, pun_last = 8'h00, c;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [2:0]  spi_irq = 3'h0;
  logic [3:0]  atu_req = 4'h0, atu_gnt, slow = 4'h0, dv, spi_class;
  logic [17:0] spi_dout, spi_din, st_wdata, st_rdata, a, w;
  logic [15:0] st_addr;
  logic [6:0]  spi_op;
  logic [1:0]  irq_level;
  int          fail_count = 0, n_compared = 0, i, n, pc = 0, pc0, rc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (pun_strobe) begin
    pc++;
    pun_last <= pun_char;
  end
  always @(posedge clk) if (rd_ack) rc++;
  pio_top dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .spi_dout, .spi_din, .spi_class, .spi_op, .spi_ctrl_word, .spi_out_stb, .spi_in_stb, .spi_ack,
    .spi_irq, .irq_level, .irq_active, .st_we, .st_addr, .st_wdata, .st_rdata, .atu_req, .atu_gnt,
    .rd_char, .rd_ready, .rd_ack, .pun_ready, .tty_ready, .pun_char, .pun_strobe);
  pio_periph p (.clk, .slow, .spi_out_stb, .spi_in_stb, .spi_ctrl_word, .spi_dout, .spi_din, .spi_ack,
    .st_we, .st_addr, .st_wdata, .st_rdata);
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) fail_count++;
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 40; k++) begin
      apb(1'h0, A_STATUS, 32'h0);
      if (rv[1] === 1'h0) break;
    end
  endtask
  task automatic cmd(input logic [3:0] d, input logic [3:0] code);
    apb(1'h1, A_CMD, {24'h0, d, code});
    wait_idle;
  endtask
  function automatic logic [17:0] tin(input logic [17:0] acc, input logic [7:0] ch);
    logic [17:0] s;
    s = acc << 7;
    return {s[17:8], s[7] | ch[7], ch[6:0]};
  endfunction
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------
  // Tests
  // ------
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  initial begin
    n = $urandom(59);
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    for (i = 0; i < 2; i++) begin
      a = 18'($urandom);
      apb(1'h1, A_ACC, {14'h0, a});
      cmd(4'h0, i ? C_CTRL : C_WORD_OUT);
      `CHK({p.last_cw, p.last_out}, {i[0], a})
    end
    w = p.word;
    cmd(4'h0, C_WORD_IN);
    apb(1'h0, A_ACC, 32'h0);
    `CHK(rv[17:0], w)
    $display("words done");
    for (i = 0; i < 16; i++) begin
      a = {7'($urandom), i[3:0], 7'($urandom)};
      apb(1'h1, A_INSTR, {14'h0, a});
      repeat (3) @(posedge clk);
      `CHK(spi_class, i[3:0])
      `CHK(spi_op, FULLOP_CLASSES[i] ? a[6:0] : {5'h0, a[1:0]})
    end
    for (i = 0; i < 8; i++) begin
      spi_irq <= i[2:0];
      repeat (3) @(posedge clk);
      `CHK({irq_active, irq_level}, {i != 0, i[0] ? 2'h1 : i[1] ? 2'h2 : i[2] ? 2'h3 : 2'h0})
    end
    for (i = 0; i < 24; i++) begin
      atu_req <= (i < 16) ? i[3:0] : 4'($urandom);
      repeat (3) @(posedge clk);
      `CHK(atu_gnt, atu_req & (~atu_req + 4'h1))
    end
    atu_req <= 4'h0;
    $display("decode done");
    for (i = 0; i < 8; i++) begin
      a = {17'($urandom), i[0]};
      c = {i[1], 7'($urandom)};
      dv = i[2] ? DEV_TTY : DEV_READER;
      rd_char <= c;
      rd_ready <= 1'h1;
      tty_ready <= i[2];
      apb(1'h1, A_ACC, {14'h0, a});
      cmd(dv, C_TAPE_IN);
      apb(1'h0, A_ACC, 32'h0);
      `CHK(rv[17:0], tin(a, c))
      `CHK(rv[7], a[0] | c[7])
    end
    `CHK(rc, 8)
    rd_ready <= 1'h0;
    a = 18'($urandom) & 18'h3FF7F;
    pc0 = pc;
    apb(1'h1, A_ACC, {14'h0, a});
    apb(1'h1, A_CMD, {24'h0, DEV_PUNCH, C_TAPE_OUT});
    repeat (6) @(posedge clk);
    apb(1'h0, A_STATUS, 32'h0);
    `CHK(rv[3], 1'h1)
    `CHK(pc, pc0)
    apb(1'h0, A_TSTAT, 32'h0);
    `CHK(rv[1], 1'h1)
    pun_ready <= 1'h1;
    wait_idle;
    `CHK(pun_last, a[7:0])
    $display("tape done");
    slow <= 4'h2;
    apb(1'h1, A_BADDR, 32'h4);
    apb(1'h1, A_BCNT, 32'h3);
    w = p.word;
    cmd(4'h0, C_BLK_IN);
    for (i = 0; i < 3; i++) `CHK(p.mem[4 + i], w + 18'(i) * p.STEP)
    apb(1'h0, A_AUX, 32'h0);
    `CHK(rv[17:0], 18'h00000)
    cmd(4'h0, C_BLK_OUT);
    `CHK({p.last_cw, p.last_out}, {1'h0, p.mem[6]})
    apb(1'h0, A_ACC, 32'h0);
    `CHK(rv[17:0], p.mem[6])
    apb(1'h0, 8'h28, 32'h0);
    `CHK({err, rv}, {1'h1, 32'h0})
    cmd(4'h0, C_ONLINE);
    apb(1'h0, A_STATUS, 32'h0);
    `CHK(rv[2], 1'h1)
    pun_ready <= 1'h0;
    pc0 = pc;
    cmd(DEV_PUNCH, C_TAPE_OUT);
    `CHK(pc, pc0)
    cmd(4'h0, C_OFFLINE);
    apb(1'h0, A_STATUS, 32'h0);
    `CHK(rv[2], 1'h0)
    cmd(4'h0, C_ONLINE);
    resetn <= 1'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    apb(1'h0, A_STATUS, 32'h0);
    `CHK(rv[3:2], 2'h0)
    $display("modes done");
    complete_run;
  end
endmodule
